// ---- logic/dtb_pkg.sv ----
// Constants shared by both ends, and the slave's address-decode function, for the byte/word transfer bus handshake.
// Assumes both ends run on mclk_in at 40 MHz and the bench resolves the wired lines.
//
// Notes on behaviour
// - Master releases address and strobe lines only when giving up ownership.
// - Master waits acknowledges high before any data strobe.
// - Slave decodes address, modifier, width, acknowledge-cycle flag.
// - Byte read: strobe zero low, strobe one high.
// - Selected slave fetches the whole word on read.
// - Slave drives the whole word, then acknowledge low.
// - Master captures low byte on acknowledge low.
// - Last cycle: release address and data strobes together, then address strobe.
// - Not last: loop straight to next address phase.
// - Slave releases data before releasing acknowledge.
// - Word write: write low, width high, data placed.
// - Word write asserts both data strobes together.
// - Slave captures sixteen lines on word write.
// - Slave stores word and asserts acknowledge in the same cycle.
// - On acknowledge, master raises strobes then address strobe.
// - Slave releases acknowledge when all strobes high.
// - Direction level settled before first data strobe.
// - Byte access: width high, address bit one low.
// - Bus timer ends slow cycle with bus error.
package dtb_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 24;
   localparam int AM_W     = 6;
   localparam int DATA_W   = 16;
   localparam int MEM_AW   = 4;
   localparam int MEM_WORDS = 16;
   // ----------------------------------------------------------------
   // Slave decode and master timing
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] SLV_BASE   = 24'h100000;
   localparam logic [ADDR_W-1:0] SLV_MASK   = 24'hFFFFE0;
   localparam logic [AM_W-1:0]   SLV_AM     = 6'h39;
   localparam int                CLK_MHZ    = 40;
   localparam int                SETUP_NS   = 50;
   localparam int                SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int                TIMEOUT_US = 64;
   localparam int                TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam int                TMR_W      = 12;

   function automatic logic dtb_addr_hit(input logic [ADDR_W-1:0] a, input logic [AM_W-1:0] am,
                                         input logic iack_n);
      dtb_addr_hit = ((a & SLV_MASK) == SLV_BASE) && (am == SLV_AM) && iack_n;
   endfunction
endpackage

// ---- logic/dtb_if.sv ----
// Interface joining the master and slave ends of the transfer bus.
// Assumes open-drain lines pulled high; the bench may add further drivers.
`timescale 1ns/100ps
interface dtb_if;
   import dtb_pkg::*;
   logic [ADDR_W-1:0] addr_o;
   logic              addr_oe;
   logic [AM_W-1:0]   am_o;
   logic              lword_n_o;
   logic              iack_n_o;
   logic              write_n_o;
   logic              as_n_o;
   logic              ds0_n_o;
   logic              ds1_n_o;
   logic              strobe_oe;
   logic [DATA_W-1:0] m_data_o;
   logic              m_data_oe;
   logic [DATA_W-1:0] s_data_o;
   logic              s_data_oe;
   logic              s_dtack_oe;
   logic              s_berr_oe;
   logic              t_berr_oe;
   // Resolved line levels; released lines float high.
   logic [ADDR_W-1:0] addr;
   logic [AM_W-1:0]   am;
   logic              lword_n;
   logic              iack_n;
   logic              write_n;
   logic              as_n;
   logic              ds0_n;
   logic              ds1_n;
   logic [DATA_W-1:0] data;
   logic              dtack_n;
   logic              berr_n;
   assign addr    = addr_oe ? addr_o : '1;
   assign am      = addr_oe ? am_o : '1;
   assign lword_n = addr_oe ? lword_n_o : 1'b1;
   assign iack_n  = addr_oe ? iack_n_o : 1'b1;
   assign write_n = strobe_oe ? write_n_o : 1'b1;
   assign as_n    = strobe_oe ? as_n_o : 1'b1;
   assign ds0_n   = strobe_oe ? ds0_n_o : 1'b1;
   assign ds1_n   = strobe_oe ? ds1_n_o : 1'b1;
   assign data    = m_data_oe ? m_data_o : (s_data_oe ? s_data_o : '1);
   assign dtack_n = ~s_dtack_oe;
   assign berr_n  = ~(s_berr_oe | t_berr_oe);
   modport master (output addr_o, addr_oe, am_o, lword_n_o, iack_n_o, write_n_o, as_n_o, ds0_n_o,
                   ds1_n_o, strobe_oe, m_data_o, m_data_oe, t_berr_oe,
                   input data, dtack_n, berr_n);
   modport slave (output s_data_o, s_data_oe, s_dtack_oe, s_berr_oe,
                  input addr, am, lword_n, iack_n, write_n, as_n, ds0_n, ds1_n, data);
endinterface

// ---- logic/dtb_slave.sv ----
// Responding slave end: a small word store reached over the transfer bus.
// Assumes the master keeps its handshake duties; bus lines come from another domain.
`timescale 1ns/100ps
module dtb_slave
   import dtb_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              reset_n_in,
   dtb_if.slave                   bus,
   output logic                   wr_seen_out,
   output logic [DATA_W-1:0]      last_wr_out
);
   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   localparam int SW = ADDR_W + AM_W + DATA_W + 6;
   logic [SW-1:0] meta;
   logic [SW-1:0] sync;
   always_ff @(posedge mclk_in) begin
      meta <= {bus.addr, bus.am, bus.data, bus.lword_n, bus.iack_n, bus.write_n, bus.as_n, bus.ds0_n,
               bus.ds1_n};
      sync <= meta;
   end
   logic [ADDR_W-1:0] s_addr;
   logic [AM_W-1:0]   s_am;
   logic [DATA_W-1:0] s_data;
   logic              s_lword_n, s_iack_n, s_write_n, s_as_n, s_ds0_n, s_ds1_n;
   assign {s_addr, s_am, s_data, s_lword_n, s_iack_n, s_write_n, s_as_n, s_ds0_n, s_ds1_n} = sync;

   // ----------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      SL_IDLE = 5'b00001,
      SL_SEL  = 5'b00010,
      SL_ACK  = 5'b00100,
      SL_REL  = 5'b01000,
      SL_SKIP = 5'b10000
   } dtb_sl_state_t;
   dtb_sl_state_t     state, next_state;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [MEM_AW-1:0] idx, next_idx;
   logic [DATA_W-1:0] dout, next_dout;
   logic              doe, next_doe, ack, next_ack, wr_seen, next_wr_seen;
   logic [DATA_W-1:0] last_wr, next_last_wr;
   logic              do_write;
   logic              ds_any;
   assign ds_any = ~s_ds0_n | ~s_ds1_n;

   always_comb begin
      next_state   = state;
      next_idx     = idx;
      next_dout    = dout;
      next_doe     = doe;
      next_ack     = ack;
      next_wr_seen = 1'b0;
      next_last_wr = last_wr;
      do_write     = 1'b0;
      unique case (state)
         SL_IDLE: begin
            if (!s_as_n) begin
               // Address latched when the strobe is seen, so pipelined changes do no harm.
               next_idx = s_addr[MEM_AW:1];
               if (dtb_addr_hit(s_addr, s_am, s_iack_n) && s_lword_n) begin
                  next_state = SL_SEL;
               end else begin
                  next_state = SL_SKIP;
               end
            end
         end
         SL_SEL: begin
            if (s_as_n) begin
               next_state = SL_IDLE;
            end else if (!s_write_n && !s_ds0_n && !s_ds1_n) begin
               do_write     = 1'b1;
               next_last_wr = s_data;
               next_wr_seen = 1'b1;
               next_ack     = 1'b1;
               next_state   = SL_ACK;
            end else if (s_write_n && !s_ds0_n && s_ds1_n) begin
               next_dout  = mem[idx];
               next_doe   = 1'b1;
               next_state = SL_ACK;
            end
         end
         SL_ACK: begin
            // Data stands one cycle before the acknowledge for reads.
            if (doe && !ack) begin
               next_ack = 1'b1;
            end else if (s_as_n && !ds_any) begin
               next_doe   = 1'b0;
               next_state = SL_REL;
            end
         end
         SL_REL: begin
            next_ack   = 1'b0;
            next_state = SL_IDLE;
         end
         SL_SKIP: begin
            if (s_as_n) begin
               next_state = SL_IDLE;
            end
         end
         default: next_state = SL_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         state   <= SL_IDLE;
         idx     <= '0;
         dout    <= '0;
         doe     <= 1'b0;
         ack     <= 1'b0;
         wr_seen <= 1'b0;
         last_wr <= '0;
      end else begin
         state   <= next_state;
         idx     <= next_idx;
         dout    <= next_dout;
         doe     <= next_doe;
         ack     <= next_ack;
         wr_seen <= next_wr_seen;
         last_wr <= next_last_wr;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (do_write) begin
         mem[idx] <= s_data;
      end
   end

   assign bus.s_data_o   = dout;
   assign bus.s_data_oe  = doe;
   assign bus.s_dtack_oe = ack;
   assign bus.s_berr_oe  = 1'b0;
   assign wr_seen_out    = wr_seen;
   assign last_wr_out    = last_wr;
endmodule // dtb_slave

// ---- logic/dtb_master.sv ----
// Master end: runs byte reads and word writes requested by on-board logic.
// Assumes one requester owns the bus; the bus timer lives here.
`timescale 1ns/100ps
module dtb_master
   import dtb_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              reset_n_in,
   input  wire logic              req_in,
   input  wire logic              req_write_in,
   input  wire logic              req_last_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   output logic                   busy_out,
   output logic                   done_out,
   output logic                   berr_out,
   output logic [7:0]             rdata_out,
   dtb_if.master                  bus
);
   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [DATA_W+1:0] meta, sync;
   always_ff @(posedge mclk_in) begin
      meta <= {bus.data, bus.dtack_n, bus.berr_n};
      sync <= meta;
   end
   logic [DATA_W-1:0] s_data;
   logic              s_dtack_n, s_berr_n;
   assign {s_data, s_dtack_n, s_berr_n} = sync;

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      MS_IDLE  = 6'b000001,
      MS_ADDR  = 6'b000010,
      MS_WAIT  = 6'b000100,
      MS_STRB  = 6'b001000,
      MS_TERM  = 6'b010000,
      MS_END   = 6'b100000
   } dtb_ms_state_t;
   dtb_ms_state_t     state, next_state;
   logic [ADDR_W-1:0] addr, next_addr;
   logic              wr, next_wr, last, next_last, aoe, next_aoe, soe, next_soe;
   logic              as_n, next_as_n, ds0_n, next_ds0_n, ds1_n, next_ds1_n;
   logic [DATA_W-1:0] wdata, next_wdata;
   logic              doe, next_doe, done, next_done, berr, next_berr, tberr, next_tberr;
   logic [7:0]        rdata, next_rdata;
   logic [TMR_W-1:0]  tmr, next_tmr;

   always_comb begin
      next_state = state;
      next_addr  = addr;
      next_wr    = wr;
      next_last  = last;
      next_aoe   = aoe;
      next_soe   = soe;
      next_as_n  = as_n;
      next_ds0_n = ds0_n;
      next_ds1_n = ds1_n;
      next_wdata = wdata;
      next_doe   = doe;
      next_done  = 1'b0;
      next_berr  = berr;
      next_rdata = rdata;
      next_tberr = 1'b0;
      next_tmr   = '0;
      unique case (state)
         MS_IDLE: begin
            if (req_in) begin
               // Bit one forced low keeps the byte on the strobe-zero lane.
               next_addr  = {req_addr_in[ADDR_W-1:2], 1'b0, req_addr_in[0]};
               next_wr    = req_write_in;
               next_last  = req_last_in;
               next_wdata = req_wdata_in;
               next_aoe   = 1'b1;
               next_soe   = 1'b1;
               next_tmr   = TMR_W'(SETUP_CYC);
               next_state = MS_ADDR;
            end
         end
         MS_ADDR: begin
            next_tmr = tmr - 1'b1;
            if (tmr == '0) begin
               next_as_n  = 1'b0;
               next_state = MS_WAIT;
            end
         end
         MS_WAIT: begin
            if (s_dtack_n && s_berr_n) begin
               next_doe   = wr;
               next_state = MS_STRB;
            end
         end
         MS_STRB: begin
            next_ds0_n = 1'b0;
            next_ds1_n = ~wr;
            next_tmr   = tmr + 1'b1;
            if (!ds0_n && (!s_dtack_n || !s_berr_n)) begin
               if (!wr) begin
                  next_rdata = s_data[7:0];
               end
               next_berr  = ~s_berr_n;
               next_aoe   = ~last;
               next_doe   = 1'b0;
               next_ds0_n = 1'b1;
               next_ds1_n = 1'b1;
               next_state = MS_TERM;
            end else if (tmr == TMR_W'(TIMEOUT_CYC - 1)) begin
               next_tberr = 1'b1;
               next_tmr   = tmr;
            end else if (tberr) begin
               next_tberr = 1'b1;
               next_tmr   = tmr;
            end
         end
         MS_TERM: begin
            next_as_n  = 1'b1;
            next_done  = 1'b1;
            next_state = MS_END;
         end
         MS_END: begin
            if (last) begin
               next_soe   = 1'b0;
               next_state = MS_IDLE;
            end else if (req_in) begin
               next_addr  = {req_addr_in[ADDR_W-1:2], 1'b0, req_addr_in[0]};
               next_wr    = req_write_in;
               next_last  = req_last_in;
               next_wdata = req_wdata_in;
               next_aoe   = 1'b1;
               next_tmr   = TMR_W'(SETUP_CYC);
               next_state = MS_ADDR;
            end
         end
         default: next_state = MS_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         state <= MS_IDLE;
         addr  <= '0;
         wr    <= 1'b0;
         last  <= 1'b1;
         aoe   <= 1'b0;
         soe   <= 1'b0;
         as_n  <= 1'b1;
         ds0_n <= 1'b1;
         ds1_n <= 1'b1;
         wdata <= '0;
         doe   <= 1'b0;
         done  <= 1'b0;
         berr  <= 1'b0;
         rdata <= '0;
         tberr <= 1'b0;
         tmr   <= '0;
      end else begin
         state <= next_state;
         addr  <= next_addr;
         wr    <= next_wr;
         last  <= next_last;
         aoe   <= next_aoe;
         soe   <= next_soe;
         as_n  <= next_as_n;
         ds0_n <= next_ds0_n;
         ds1_n <= next_ds1_n;
         wdata <= next_wdata;
         doe   <= next_doe;
         done  <= next_done;
         berr  <= next_berr;
         rdata <= next_rdata;
         tberr <= next_tberr;
         tmr   <= next_tmr;
      end
   end

   logic busy;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         busy <= 1'b0;
      end else begin
         busy <= (next_state != MS_IDLE) && (next_state != MS_END);
      end
   end

   assign bus.addr_o    = addr;
   assign bus.addr_oe   = aoe;
   assign bus.am_o      = SLV_AM;
   assign bus.lword_n_o = 1'b1;
   assign bus.iack_n_o  = 1'b1;
   assign bus.write_n_o = ~wr;
   assign bus.as_n_o    = as_n;
   assign bus.ds0_n_o   = ds0_n;
   assign bus.ds1_n_o   = ds1_n;
   assign bus.strobe_oe = soe;
   assign bus.m_data_o  = wdata;
   assign bus.m_data_oe = doe;
   assign bus.t_berr_oe = tberr;
   assign busy_out      = busy;
   assign done_out      = done;
   assign berr_out      = berr;
   assign rdata_out     = rdata;
endmodule // dtb_master

// ---- verif/dtb_checker.sv ----
// Concurrent checks on the resolved lines and drive enables of the transfer bus between both ends.
// Assumes one clock domain, mclk_in, and a synchronous active-low reset.
`timescale 1ns/100ps
module dtb_checker
   import dtb_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              reset_n_in,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [AM_W-1:0]   am,
   input  wire logic              addr_oe,
   input  wire logic              lword_n,
   input  wire logic              iack_n,
   input  wire logic              write_n,
   input  wire logic              as_n,
   input  wire logic              ds0_n,
   input  wire logic              ds1_n,
   input  wire logic              dtack_n,
   input  wire logic              berr_n,
   input  wire logic              m_data_oe,
   input  wire logic              s_data_oe,
   input  wire logic              s_dtack_oe,
   input  wire logic              s_berr_oe,
   input  wire logic              t_berr_oe
);
   // ----------------------------------------------------------------
   // Decode seen from the bus
   // ----------------------------------------------------------------
   logic hit;
   assign hit = ((addr & SLV_MASK) == SLV_BASE) && (am == SLV_AM) && iack_n && lword_n;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   // The slave and master each need a few cycles of synchroniser lag.
   sequence ack_gone;
      ##[1:8] !s_dtack_oe;
   endsequence
   sequence strobe_drop;
      ##[1:8] ds0_n;
   endsequence

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   ds_wait_ack_a: assert property ($fell(ds0_n) |-> dtack_n && berr_n && !as_n)
      else $error("data strobe fell with a response still low");
   dir_settled_a: assert property ($fell(ds0_n) |-> $stable(write_n))
      else $error("direction moved as the strobe fell");
   byte_form_a: assert property ((!ds0_n && write_n) |-> ds1_n && lword_n && !addr[1] && addr_oe)
      else $error("byte read strobes or width wrong");
   word_form_a: assert property ((!ds0_n && !write_n) |-> !ds1_n && lword_n && m_data_oe)
      else $error("word write strobes or data wrong");
   read_drive_a: assert property (($rose(s_dtack_oe) && write_n) |-> s_data_oe)
      else $error("read acknowledged without data");
   dtack_cause_a: assert property ($rose(s_dtack_oe) |-> !ds0_n && !as_n && hit)
      else $error("acknowledge without a selected strobed cycle");
   unsel_quiet_a: assert property ((!ds0_n && !hit) |-> !s_data_oe && !s_dtack_oe && !s_berr_oe)
      else $error("unselected slave drove the bus");
   data_first_a: assert property ($fell(s_data_oe) |-> s_dtack_oe)
      else $error("acknowledge released before data");
   dtack_release_a: assert property ((s_dtack_oe && as_n && ds0_n && ds1_n) |-> ack_gone)
      else $error("acknowledge held after strobes rose");
   ds_interlock_a: assert property ($rose(ds0_n) |-> !$past(dtack_n) || !$past(berr_n))
      else $error("strobe rose without a response");
   as_last_a: assert property ($rose(as_n) |-> ds0_n && ds1_n)
      else $error("address strobe rose before data strobes");
   timer_end_a: assert property ($rose(t_berr_oe) |-> !ds0_n ##0 strobe_drop)
      else $error("bus error did not end the cycle");
endmodule // dtb_checker

// ---- verif/dtb_byte_word_handshake_test.sv ----
// Self-checking bench joining master and slave ends through the bus interface.
// Assumes a 40 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
module dtb_byte_word_handshake_test;
   import dtb_pkg::*;
   logic              mclk_in;
   logic              reset_n_in;
   logic              req_in;
   logic              req_write_in;
   logic              req_last_in;
   logic [ADDR_W-1:0] req_addr_in;
   logic [DATA_W-1:0] req_wdata_in;
   logic              busy_out;
   logic              done_out;
   logic              berr_out;
   logic [7:0]        rdata_out;
   logic              wr_seen_out;
   logic [DATA_W-1:0] last_wr_out;
   int                n_mismatch;
   int                checks;
   int                n_wr;

   dtb_if u_dtb_if();
   dtb_master u_dtb_master (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_in(req_in),
      .req_write_in(req_write_in), .req_last_in(req_last_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .busy_out(busy_out), .done_out(done_out), .berr_out(berr_out),
      .rdata_out(rdata_out), .bus(u_dtb_if.master));
   dtb_slave u_dtb_slave (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus(u_dtb_if.slave),
      .wr_seen_out(wr_seen_out), .last_wr_out(last_wr_out));
   dtb_checker u_dtb_checker (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr(u_dtb_if.addr),
      .am(u_dtb_if.am), .addr_oe(u_dtb_if.addr_oe), .lword_n(u_dtb_if.lword_n), .iack_n(u_dtb_if.iack_n),
      .write_n(u_dtb_if.write_n), .as_n(u_dtb_if.as_n), .ds0_n(u_dtb_if.ds0_n), .ds1_n(u_dtb_if.ds1_n),
      .dtack_n(u_dtb_if.dtack_n), .berr_n(u_dtb_if.berr_n), .m_data_oe(u_dtb_if.m_data_oe),
      .s_data_oe(u_dtb_if.s_data_oe), .s_dtack_oe(u_dtb_if.s_dtack_oe), .s_berr_oe(u_dtb_if.s_berr_oe),
      .t_berr_oe(u_dtb_if.t_berr_oe));

   // ----------------------------------------------------------------
   // Clock, write counter, watchdog
   // ----------------------------------------------------------------
   initial mclk_in = 1'b0;
   always #12.5 mclk_in = ~mclk_in;
   // Sampled on the falling edge so the one-cycle pulse is read once, away from its launch edge.
   always @(negedge mclk_in) if (wr_seen_out === 1'b1) n_wr++;
   // The bus-error test alone waits out the whole timer, so allow several times that.
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      finish_test();
   end

   task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus cycle; returns at the falling edge where done is seen.
   task automatic run_cycle(input logic wr, input logic last, input logic [23:0] a, input logic [15:0] wd);
      int n;
      @(negedge mclk_in);
      req_write_in = wr;
      req_last_in  = last;
      req_addr_in  = a;
      req_wdata_in = wd;
      req_in       = 1'b1;
      @(negedge mclk_in);
      req_in = 1'b0;
      cmp_flag(busy_out, 1'b1);
      n = 0;
      while (done_out !== 1'b1 && n < 4000) begin
         @(negedge mclk_in);
         n++;
      end
      cmp_flag(n < 4000, 1'b1);
      cmp_flag(u_dtb_if.addr_oe, !last);
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      cmp_flag(busy_out, 1'b0);
      cmp_flag(berr_out, 1'b0);
      cmp_data({8'h00, rdata_out}, 16'h0000);
      cmp_flag(u_dtb_if.strobe_oe, 1'b0);
      $display("t_reset done");
   endtask

   task automatic t_write_read();
      run_cycle(1'b1, 1'b1, 24'h100006, 16'hA55A);
      cmp_data(last_wr_out, 16'hA55A);
      run_cycle(1'b0, 1'b1, 24'h100006, 16'h0000);
      cmp_data({8'h00, rdata_out}, 16'h005A);
      cmp_flag(berr_out, 1'b0);
      $display("t_write_read done");
   endtask

   // Chained cycles: the master loops back to the address phase between them.
   task automatic t_chained();
      run_cycle(1'b1, 1'b0, 24'h100000, 16'h0102);
      run_cycle(1'b1, 1'b0, 24'h10001E, 16'hF00F);
      cmp_data(last_wr_out, 16'hF00F);
      run_cycle(1'b0, 1'b0, 24'h10001E, 16'h0000);
      cmp_data({8'h00, rdata_out}, 16'h000F);
      run_cycle(1'b0, 1'b1, 24'h100000, 16'h0000);
      cmp_data({8'h00, rdata_out}, 16'h0002);
      $display("t_chained done");
   endtask

   // First address past the slave window: only the bus timer can end it.
   task automatic t_bus_error();
      run_cycle(1'b0, 1'b1, 24'h100020, 16'h0000);
      cmp_flag(berr_out, 1'b1);
      run_cycle(1'b0, 1'b1, 24'h10001E, 16'h0000);
      cmp_flag(berr_out, 1'b0);
      cmp_data({8'h00, rdata_out}, 16'h000F);
      $display("t_bus_error done");
   endtask

   initial begin
      n_mismatch   = 0;
      checks       = 0;
      n_wr         = 0;
      reset_n_in   = 1'b0;
      req_in       = 1'b0;
      req_write_in = 1'b0;
      req_last_in  = 1'b0;
      req_addr_in  = 24'h000000;
      req_wdata_in = 16'h0000;
      repeat (4) @(negedge mclk_in);
      reset_n_in = 1'b1;
      t_reset();
      t_write_read();
      t_chained();
      t_bus_error();
      cmp_data(16'(n_wr), 16'h0003);
      finish_test();
   end
endmodule // dtb_byte_word_handshake_test
